// file: rtl/epo_regs.svh
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH
// Register byte offsets
`define EPO_OFS_CTRL       8'h00
`define EPO_OFS_RESOLUTION 8'h04
`define EPO_OFS_INDEX_POS  8'h08
`define EPO_OFS_POLES      8'h0C
`define EPO_OFS_GEAR_SRC   8'h10
`define EPO_OFS_POSITION   8'h14
`define EPO_OFS_FOLLOW_POS 8'h18
`define EPO_OFS_STATUS     8'h1C
// Control field positions
`define EPO_CTRL_CH_LSB    0
`define EPO_CTRL_FMT_LSB   4
`define EPO_CTRL_FOL_EN    6
`define EPO_CTRL_FFMT_LSB  7
`define EPO_CTRL_ADAPT_P2  9
// Reset values and gearing source limit
`define EPO_RST_CTRL       10'h000
`define EPO_RST_RESOLUTION 16'h1000
`define EPO_RST_INDEX_POS  16'h0000
`define EPO_RST_POLES      5'h02
`define EPO_RST_GEAR_SRC   3'h0
`define EPO_GEAR_SRC_MAX   3'h4
// Timing: clock rate and highest output signal frequency
`define EPO_CLK_KHZ        50000
`define EPO_MAX_OUT_KHZ    3000
`define EPO_QUAD_GAP       ((`EPO_CLK_KHZ + 4 * `EPO_MAX_OUT_KHZ - 1) / (4 * `EPO_MAX_OUT_KHZ))
`define EPO_PULSE_GAP      ((`EPO_CLK_KHZ + `EPO_MAX_OUT_KHZ - 1) / `EPO_MAX_OUT_KHZ)
`define EPO_PULSE_HI       ((`EPO_PULSE_GAP + 1) / 2)
`endif

// file: rtl/epo_pkg.sv
package epo_pkg;
  // Output and follower signal formats
  typedef enum logic [1:0] {EPO_FMT_QUAD, EPO_FMT_CWCCW, EPO_FMT_PDIR, EPO_FMT_RSVD} epo_fmt_t;
endpackage

// file: rtl/epo_top.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "epo_regs.svh"
// Notes on behaviour
// - Shaft position from feedback leaves as quadrature, CW/CCW or pulse/direction signals.
// - Output resolution and index position are software settings.
// - Multispeed resolver above two poles still gives one index per mechanical turn.
// - Index location with a multispeed resolver is relative to startup position.
// - Backplane channel carries tracks A and B only, in quadrature.
// - Sub-D channels carry A, B in quadrature plus an index track.
// - No output channel toggles faster than 3 MHz.
// - Pulses per turn are programmable; A/B phase stays within 90 plus/minus 20 degrees.
// - Adapter output is logical channel three on port one, four otherwise.
// - In slave role, incoming pulses give commanded velocity and direction.
// - Gearing command source selects any of five feedback channels.
module epo_top
  import epo_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] fb_angle,
  input  wire logic        fb_valid,
  input  wire logic        follow_in_a,
  input  wire logic        follow_in_b,
  output logic             subd_pulse_out_ch_a,
  output logic             subd_pulse_out_ch_b,
  output logic             subd_pulse_out_ch_z,
  output logic             backplane_pulse_out_ch_a,
  output logic             backplane_pulse_out_ch_b,
  output logic             adapter_pulse_out_port1_a,
  output logic             adapter_pulse_out_port1_b,
  output logic             adapter_pulse_out_port1_z,
  output logic             adapter_pulse_out_port2_a,
  output logic             adapter_pulse_out_port2_b,
  output logic             adapter_pulse_out_port2_z,
  output logic             follow_step,
  output logic             follow_dir,
  output logic [2:0]       gearing_source_select
);

  localparam logic [4:0] QUAD_GAP = 5'(`EPO_QUAD_GAP);
  localparam logic [4:0] PULSE_GAP = 5'(`EPO_PULSE_GAP);
  localparam logic [4:0] PULSE_HI = 5'(`EPO_PULSE_HI);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB slave
  logic [9:0]  ctrl_q;
  logic [15:0] res_q;
  logic [15:0] idx_q;
  logic [4:0]  poles_q;
  logic [2:0]  gear_q;
  logic [15:0] cnt_q;
  logic [31:0] fpos_q;
  logic        dir_q;
  logic        index_hit;
  logic        wr_en;
  logic        mapped;
  epo_fmt_t    fmt;
  epo_fmt_t    ffmt;

  assign fmt = epo_fmt_t'(ctrl_q[`EPO_CTRL_FMT_LSB +: 2]);
  assign ffmt = epo_fmt_t'(ctrl_q[`EPO_CTRL_FFMT_LSB +: 2]);
  assign wr_en = ce & psel & penable & pwrite & mapped;
  assign gearing_source_select = gear_q;

  // Address decode, shared by write enable and error answer
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= `EPO_OFS_STATUS);
  endfunction

  // Slave answers in the first access cycle unless frozen
  assign mapped = addr_ok(paddr);
  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;

  // Software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `EPO_RST_CTRL;
      res_q   <= `EPO_RST_RESOLUTION;
      idx_q   <= `EPO_RST_INDEX_POS;
      poles_q <= `EPO_RST_POLES;
      gear_q  <= `EPO_RST_GEAR_SRC;
    end else if (wr_en) begin
      case (paddr)
        `EPO_OFS_CTRL:       ctrl_q <= pwdata[9:0];
        `EPO_OFS_RESOLUTION: if (pwdata[15:0] != 16'h0000) res_q <= pwdata[15:0];
        `EPO_OFS_INDEX_POS:  idx_q <= pwdata[15:0];
        `EPO_OFS_POLES:      poles_q <= pwdata[4:0];
        `EPO_OFS_GEAR_SRC:   if (pwdata[2:0] <= `EPO_GEAR_SRC_MAX) gear_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        `EPO_OFS_CTRL:       prdata <= {22'h0, ctrl_q};
        `EPO_OFS_RESOLUTION: prdata <= {16'h0, res_q};
        `EPO_OFS_INDEX_POS:  prdata <= {16'h0, idx_q};
        `EPO_OFS_POLES:      prdata <= {27'h0, poles_q};
        `EPO_OFS_GEAR_SRC:   prdata <= {29'h0, gear_q};
        `EPO_OFS_POSITION:   prdata <= {16'h0, cnt_q};
        `EPO_OFS_FOLLOW_POS: prdata <= fpos_q;
        `EPO_OFS_STATUS:     prdata <= {29'h0, index_hit, follow_dir, dir_q};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback angle to output steps
  logic [15:0]        last_q;
  logic               primed_q;
  logic signed [39:0] frac_q;
  logic signed [39:0] add;
  logic signed [39:0] thr;
  logic signed [39:0] wdelta;
  logic signed [39:0] wres;
  logic [3:0]         pairs;
  logic [15:0]        delta;
  logic [4:0]         gap_q;
  logic               run;
  logic               step_up;
  logic               step_dn;
  logic               step;

  assign run = ctrl_q[`EPO_CTRL_CH_LSB +: 4] != 4'h0;
  // Electrical turns per mechanical turn scale the threshold
  assign pairs = (poles_q[4:1] == 4'h0) ? 4'h1 : poles_q[4:1];
  assign thr = {20'h0, pairs, 16'h0000};
  assign delta = fb_angle - last_q;
  assign wdelta = {{24{delta[15]}}, delta};
  assign wres = {24'h0, res_q};
  assign add = (fb_valid && primed_q) ? wdelta * wres : 40'sh0;
  assign step_up = run && (gap_q == 5'h00) && (frac_q >= thr);
  assign step_dn = run && (gap_q == 5'h00) && (frac_q <= -thr);
  assign step = step_up | step_dn;

  // Phase accumulator; first sample only primes, so zero is the startup angle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q   <= 16'h0000;
      primed_q <= 1'b0;
      frac_q   <= 40'sh0;
    end else if (ce) begin
      if (fb_valid) begin
        last_q   <= fb_angle;
        primed_q <= 1'b1;
      end
      frac_q <= frac_q + add - (step_up ? thr : 40'sh0) + (step_dn ? thr : 40'sh0);
    end
  end

  // Step spacing keeps every track at or below the frequency limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 5'h00;
    end else if (ce) begin
      if (step) begin
        gap_q <= ((fmt == EPO_FMT_QUAD) ? QUAD_GAP : PULSE_GAP) - 5'h01;
      end else if (gap_q != 5'h00) begin
        gap_q <= gap_q - 5'h01;
      end
    end
  end

  // Position modulo resolution; counts a mechanical turn from startup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      dir_q <= 1'b0;
    end else if (ce) begin
      if (step_up) begin
        cnt_q <= (cnt_q >= res_q - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
        dir_q <= 1'b0;
      end else if (step_dn) begin
        cnt_q <= (cnt_q == 16'h0000 || cnt_q >= res_q) ? res_q - 16'h0001 : cnt_q - 16'h0001;
        dir_q <= 1'b1;
      end else if (cnt_q >= res_q) begin
        cnt_q <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Track generation
  logic [1:0] qs_q;
  logic [4:0] phi_q;
  logic       trk_a;
  logic       trk_b;
  logic [3:0] ch_a_q;
  logic [3:0] ch_b_q;
  logic [3:0] ch_z_q;
  logic [3:0] ch_on;

  // Quadrature state counter; gray decode gives A leading B upward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qs_q  <= 2'h0;
      phi_q <= 5'h00;
    end else if (ce) begin
      if (step_up) qs_q <= qs_q + 2'h1;
      else if (step_dn) qs_q <= qs_q - 2'h1;
      if (step) phi_q <= PULSE_HI;
      else if (phi_q != 5'h00) phi_q <= phi_q - 5'h01;
    end
  end

  // Format selection for the two tracks
  always_comb begin
    case (fmt)
      EPO_FMT_CWCCW: begin
        trk_a = (phi_q != 5'h00) & ~dir_q;
        trk_b = (phi_q != 5'h00) & dir_q;
      end
      EPO_FMT_PDIR: begin
        trk_a = phi_q != 5'h00;
        trk_b = dir_q;
      end
      default: begin
        trk_a = qs_q[1] ^ qs_q[0];
        trk_b = qs_q[1];
      end
    endcase
  end

  // Index in the quadrature state at the set position; decoded from the position
  // count, which steps in the same cycle as the tracks, so the channel register keeps it aligned with A and B
  assign index_hit = (fmt == EPO_FMT_QUAD) && run && (cnt_q == idx_q);

  // Channel enables; adapter placement picks logical channel three or four
  assign ch_on = {ctrl_q[3] & ctrl_q[`EPO_CTRL_ADAPT_P2],
                  ctrl_q[2] & ~ctrl_q[`EPO_CTRL_ADAPT_P2],
                  ctrl_q[1:0]};

  // Registered channel outputs
  for (genvar i = 0; i < 4; i++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ch_a_q[i] <= 1'b0;
        ch_b_q[i] <= 1'b0;
        ch_z_q[i] <= 1'b0;
      end else if (ce) begin
        ch_a_q[i] <= ch_on[i] & trk_a;
        ch_b_q[i] <= ch_on[i] & trk_b;
        ch_z_q[i] <= ch_on[i] & index_hit & (i != 1);
      end
    end
  end

  assign subd_pulse_out_ch_a = ch_a_q[0];
  assign subd_pulse_out_ch_b = ch_b_q[0];
  assign subd_pulse_out_ch_z = ch_z_q[0];
  assign backplane_pulse_out_ch_a = ch_a_q[1];
  assign backplane_pulse_out_ch_b = ch_b_q[1];
  assign adapter_pulse_out_port1_a = ch_a_q[2];
  assign adapter_pulse_out_port1_b = ch_b_q[2];
  assign adapter_pulse_out_port1_z = ch_z_q[2];
  assign adapter_pulse_out_port2_a = ch_a_q[3];
  assign adapter_pulse_out_port2_b = ch_b_q[3];
  assign adapter_pulse_out_port2_z = ch_z_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Follower input: synchronise, decode, count
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic       f_up;
  logic       f_dn;

  // Two-flop synchroniser plus one history stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
    end else if (ce) begin
      s1_q <= {follow_in_a, follow_in_b};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Decode one step from old and new track levels
  always_comb begin
    f_up = 1'b0;
    f_dn = 1'b0;
    case (ffmt)
      EPO_FMT_CWCCW: begin
        f_up = s2_q[1] & ~s3_q[1];
        f_dn = s2_q[0] & ~s3_q[0];
      end
      EPO_FMT_PDIR: begin
        f_up = s2_q[1] & ~s3_q[1] & ~s2_q[0];
        f_dn = s2_q[1] & ~s3_q[1] & s2_q[0];
      end
      default: begin
        f_up = (s3_q[1] != s2_q[1]) & (s3_q[0] == s2_q[0]) & (s2_q[1] != s2_q[0])
             | (s3_q[0] != s2_q[0]) & (s3_q[1] == s2_q[1]) & (s2_q[0] == s2_q[1]);
        f_dn = (s3_q != s2_q) & (s3_q != ~s2_q) & ~f_up;
      end
    endcase
    f_up = f_up & ctrl_q[`EPO_CTRL_FOL_EN];
    f_dn = f_dn & ctrl_q[`EPO_CTRL_FOL_EN];
  end

  // Commanded position, step strobe and direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fpos_q      <= 32'h0000_0000;
      follow_step <= 1'b0;
      follow_dir  <= 1'b0;
    end else if (ce) begin
      follow_step <= f_up | f_dn;
      if (f_up) begin
        fpos_q     <= fpos_q + 32'h0000_0001;
        follow_dir <= 1'b0;
      end else if (f_dn) begin
        fpos_q     <= fpos_q - 32'h0000_0001;
        follow_dir <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_stepped_up;
    step_up && ce;
  endsequence

  property p_step_gap;
    @(posedge pclk) disable iff (!presetn) (step && ce) |=> !step [*4];
  endproperty
  a_step_gap: assert property (p_step_gap) else $error("Steps closer than frequency limit");

  property p_up_order;
    @(posedge pclk) disable iff (!presetn) s_stepped_up |=> qs_q == $past(qs_q) + 2'h1;
  endproperty
  a_up_order: assert property (p_up_order) else $error("Up step did not advance A before B");

  property p_dn_order;
    @(posedge pclk) disable iff (!presetn) (step_dn && ce) |=> qs_q == $past(qs_q) - 2'h1;
  endproperty
  a_dn_order: assert property (p_dn_order) else $error("Down step did not lead with B");

  property p_one_track;
    @(posedge pclk) disable iff (!presetn)
      (fmt == EPO_FMT_QUAD && $stable(fmt)) |-> !($changed(trk_a) && $changed(trk_b));
  endproperty
  a_one_track: assert property (p_one_track) else $error("Both tracks changed together");

  property p_index_pos;
    @(posedge pclk) disable iff (!presetn) subd_pulse_out_ch_z |-> $past(cnt_q) == $past(idx_q);
  endproperty
  a_index_pos: assert property (p_index_pos) else $error("Index away from set position");

  property p_cnt_range;
    @(posedge pclk) disable iff (!presetn) (step && ce) |=> cnt_q < res_q;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("Position beyond resolution");

  property p_adapter_map;
    @(posedge pclk) disable iff (!presetn)
      ctrl_q[`EPO_CTRL_ADAPT_P2] [*2] |-> !adapter_pulse_out_port1_a && !adapter_pulse_out_port1_z;
  endproperty
  a_adapter_map: assert property (p_adapter_map) else $error("Port one active while adapter on port two");

  property p_gear_range;
    @(posedge pclk) disable iff (!presetn) gearing_source_select <= `EPO_GEAR_SRC_MAX;
  endproperty
  a_gear_range: assert property (p_gear_range) else $error("Gearing source out of range");

  property p_follow;
    @(posedge pclk) disable iff (!presetn) (f_up && ce) |=> follow_step && fpos_q == $past(fpos_q) + 32'h1;
  endproperty
  a_follow: assert property (p_follow) else $error("Follower step not counted");

  property p_no_bp_index;
    @(posedge pclk) disable iff (!presetn) ch_z_q[1] == 1'b0;
  endproperty
  a_no_bp_index: assert property (p_no_bp_index) else $error("Backplane channel has index");

endmodule

// file: testbench/epo_follower_model.sv
`timescale 1ns/1ps
// Far side of one channel: decodes tracks and can act as a master's pulse source
module epo_follower_model (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   trk_a,
  input  wire logic   trk_b,
  input  wire logic   trk_z,
  output logic        pin_a,
  output logic        pin_b,
  output logic [31:0] cnt,
  output logic [31:0] n_bad,
  output logic [31:0] n_ra,
  output logic [31:0] n_rb,
  output logic [31:0] n_rz,
  output logic [31:0] gap_min
);
  logic [1:0]  s_q;
  logic [2:0]  h_q;
  logic [31:0] gap_q;
  logic [1:0]  s_w;
  logic [1:0]  d_w;

  assign s_w = {trk_b, trk_a ^ trk_b};
  assign d_w = s_w - s_q;
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Gray decode, rising-edge counts and shortest spacing of state changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {s_q, h_q, cnt, n_bad, n_ra, n_rb, n_rz, gap_q} <= '0;
      gap_min <= 32'h3E8;
    end else begin
      h_q   <= {trk_a, trk_b, trk_z};
      s_q   <= s_w;
      gap_q <= gap_q + 32'h1;
      if (d_w != 2'h0) begin
        gap_q <= 32'h1;
        if (gap_q < gap_min) gap_min <= gap_q;
        if (d_w == 2'h1) cnt <= cnt + 32'h1;       // A leads B going up
        else if (d_w == 2'h3) cnt <= cnt - 32'h1;  // B leads A going down
        else n_bad <= n_bad + 32'h1;               // Two tracks at once
      end
      if (trk_a && !h_q[2]) n_ra <= n_ra + 32'h1;
      if (trk_b && !h_q[1]) n_rb <= n_rb + 32'h1;
      if (trk_z && !h_q[0]) n_rz <= n_rz + 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Master pulse source: one gray step every 8 cycles
  task send(input int n, input logic up);
    logic [1:0] st;
    for (int i = 0; i < n; i++) begin
      st = {pin_b, pin_a ^ pin_b} + (up ? 2'h1 : 2'h3);
      pin_b <= st[1];
      pin_a <= st[1] ^ st[0];
      repeat (8) @(posedge pclk);
    end
  endtask
endmodule

// file: testbench/epo_top_tb.sv
`timescale 1ns/1ps
`include "epo_regs.svh"
// Self-checking bench for the emulated pulse output block
module epo_top_tb;
  import epo_pkg::*;
  logic        pclk, presetn, ce, psel, penable, pwrite, fb_valid, follow_step, follow_dir, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, bad_count, n_compared, cyc, n_step, ra0, rb0;
  logic [15:0] fb_angle, ang_q;
  logic [2:0]  gsel;
  wire  [3:0]  ta, tb_, tz, pa, pb;
  wire  [31:0] m_cnt [4], m_bad [4], m_ra [4], m_rb [4], m_rz [4], m_gap [4];

  assign tz[1] = 1'b0;
  epo_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fb_angle(fb_angle),
    .fb_valid(fb_valid), .follow_in_a(pa[0]), .follow_in_b(pb[0]), .subd_pulse_out_ch_a(ta[0]),
    .subd_pulse_out_ch_b(tb_[0]), .subd_pulse_out_ch_z(tz[0]), .backplane_pulse_out_ch_a(ta[1]),
    .backplane_pulse_out_ch_b(tb_[1]), .adapter_pulse_out_port1_a(ta[2]), .adapter_pulse_out_port1_b(tb_[2]),
    .adapter_pulse_out_port1_z(tz[2]), .adapter_pulse_out_port2_a(ta[3]), .adapter_pulse_out_port2_b(tb_[3]),
    .adapter_pulse_out_port2_z(tz[3]), .follow_step(follow_step), .follow_dir(follow_dir),
    .gearing_source_select(gsel));
  // One far-side model per channel
  for (genvar i = 0; i < 4; i++) begin : g_m
    epo_follower_model u_m (.pclk(pclk), .presetn(presetn), .trk_a(ta[i]), .trk_b(tb_[i]), .trk_z(tz[i]),
      .pin_a(pa[i]), .pin_b(pb[i]), .cnt(m_cnt[i]), .n_bad(m_bad[i]), .n_ra(m_ra[i]), .n_rb(m_rb[i]),
      .n_rz(m_rz[i]), .gap_min(m_gap[i]));
  end
  //////////////////////////////////////////////////////////////////////////////
  // Clock, hang guard and follower pulse count
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 32'h1;
    if (follow_step === 1'b1) n_step <= n_step + 32'h1;
    if (cyc == 32'd50000) begin
      bad_count = bad_count + 32'h1;
      final_report;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Compare, report and bus tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 32'h1;
    if (got !== exp) begin
      bad_count = bad_count + 32'h1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("compared=%0d bad=%0d", n_compared, bad_count);
    if (bad_count == 32'h0 && n_compared > 32'h0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) bad_count = bad_count + 32'h1;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Feedback samples, each advancing the angle by step
  task fb(input logic [15:0] step, input int n);
    for (int i = 0; i < n; i++) begin
      ang_q = ang_q + step;
      fb_angle <= ang_q;
      fb_valid <= 1'b1;
      @(posedge pclk);
      fb_valid <= 1'b0;
      @(posedge pclk);
    end
  endtask
  // Wait for a channel to reach a count, then check it has not overshot
  task settle(input int ch, input logic [31:0] exp);
    for (int k = 0; k < 3000 && m_cnt[ch] !== exp; k++) @(posedge pclk);
    repeat (40) @(posedge pclk);
    chk(m_cnt[ch], exp);
  endtask
  task bases;
    repeat (10) @(posedge pclk);
    ra0 = m_ra[0];
    rb0 = m_rb[0];
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, fb_valid, paddr, pwdata, fb_angle, ang_q} = '0;
    {bad_count, n_compared, cyc, n_step} = '0;
    ce = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`EPO_OFS_CTRL, 32'h0);
    rdc(`EPO_OFS_RESOLUTION, 32'h1000);
    rdc(`EPO_OFS_INDEX_POS, 32'h0);
    rdc(`EPO_OFS_POLES, 32'h2);
    rdc(`EPO_OFS_GEAR_SRC, 32'h0);
    rdc(8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int g = 0; g < 6; g++) begin
      apb(1'b1, `EPO_OFS_GEAR_SRC, g);
      chk({29'h0, gsel}, (g > 4) ? 32'h4 : g);
    end
    apb(1'b1, `EPO_OFS_RESOLUTION, 32'h10);
    apb(1'b1, `EPO_OFS_INDEX_POS, 32'h3);
    apb(1'b1, `EPO_OFS_CTRL, 32'h00F);
    fb(16'h0000, 1);
    fb(16'h1000, 4);
    settle(0, 32'h4);
    chk(m_cnt[1], 32'h4);
    chk(m_cnt[2], 32'h4);
    chk(m_cnt[3], 32'h0);
    fb(16'hF000, 2);
    settle(0, 32'h2);
    chk(m_rz[0], 32'h2);
    chk(m_rz[2], 32'h2);
    rdc(`EPO_OFS_POSITION, 32'h2);
    fb(16'h1000, 16);
    settle(0, 32'h12);
    chk(m_rz[0], 32'h3);
    chk(m_bad[0], 32'h0);
    chk(32'(m_gap[0] >= `EPO_QUAD_GAP), 32'h1);
    // Clockwise/counter-clockwise: the 9-cycle pulses stay 17 cycles apart
    apb(1'b1, `EPO_OFS_CTRL, 32'h001 | (32'(EPO_FMT_CWCCW) << 4));
    bases;
    fb(16'h1000, 3);
    repeat (3 * `EPO_PULSE_GAP + 40) @(posedge pclk);
    chk(m_ra[0] - ra0, 32'h3);
    fb(16'hF000, 2);
    repeat (2 * `EPO_PULSE_GAP + 40) @(posedge pclk);
    chk(m_rb[0] - rb0, 32'h2);
    // Pulse and direction
    apb(1'b1, `EPO_OFS_CTRL, 32'h001 | (32'(EPO_FMT_PDIR) << 4));
    bases;
    fb(16'hF000, 2);
    repeat (2 * `EPO_PULSE_GAP + 40) @(posedge pclk);
    chk(m_ra[0] - ra0, 32'h2);
    chk({31'h0, tb_[0]}, 32'h1);
    // Follower: ignored while disabled, then counts both ways
    apb(1'b1, `EPO_OFS_CTRL, 32'h001);
    g_m[0].u_m.send(2, 1'b1);
    rdc(`EPO_OFS_FOLLOW_POS, 32'h0);
    apb(1'b1, `EPO_OFS_CTRL, 32'h041);
    g_m[0].u_m.send(5, 1'b1);
    chk({31'h0, follow_dir}, 32'h0);
    g_m[0].u_m.send(2, 1'b0);
    rdc(`EPO_OFS_FOLLOW_POS, 32'h3);
    chk({31'h0, follow_dir}, 32'h1);
    // Clockwise/counter-clockwise input: B rise counts down, A rise up
    apb(1'b1, `EPO_OFS_CTRL, 32'h0C1);
    g_m[0].u_m.send(4, 1'b1);
    rdc(`EPO_OFS_FOLLOW_POS, 32'h3);
    chk({31'h0, follow_dir}, 32'h0);
    // Pulse/direction input: only A rises count, up with B low
    apb(1'b1, `EPO_OFS_CTRL, 32'h141);
    g_m[0].u_m.send(4, 1'b1);
    rdc(`EPO_OFS_FOLLOW_POS, 32'h4);
    chk(n_step, 32'hA);
    // Second reset: six-pole resolver, adapter on port two, index at startup
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, `EPO_OFS_POLES, 32'h6);
    apb(1'b1, `EPO_OFS_RESOLUTION, 32'h10);
    apb(1'b1, `EPO_OFS_CTRL, 32'h20F);
    ang_q = 16'h5A00;
    fb(16'h0000, 1);
    repeat (20) @(posedge pclk);
    chk({31'h0, tz[0]}, 32'h1);
    fb(16'h2000, 24);
    settle(0, 32'h10);
    chk(m_rz[0], 32'h2);
    chk(m_cnt[3], 32'h10);
    chk(m_cnt[2], 32'h0);
    chk(m_rz[3], 32'h2);
    rdc(`EPO_OFS_STATUS, 32'h4);
    final_report;
  end
endmodule
